// [sfb_button.sv]
// reset push-button model for the operator reset line
`timescale 1ns/1ps
module sfb_button (
  input  wire logic sys_clk,
  output logic      operator_reset
);
  // released button rests low, so the line never floats
  initial operator_reset = 1'h0;
  // press for n clock cycles, changed only right after an edge
  task automatic hold(input int n);
    operator_reset <= 1'h1;
    repeat (n) @(posedge sys_clk);
    operator_reset <= 1'h0;
  endtask : hold
endmodule : sfb_button

// [sfb_pkg.sv]
// package with register map, timing constants and state types of the safety function blocks
// How it works
// R1: no override request: output follows safety source
// R2: override forces On unless force-off option applies
// R3: expired bypass timer drives output Off
// R4: bypass limit 1 s to 12 h, always active
// R5: one bypass limit shared by all
// R6: after bypass, source regains output control
// R7: two-hand actuated while bypassed issues Stop
// R8: enable block wired straight to output block
// R9: unbypassable stop always stops in enable mode
// R10: enable mode starts on switch to Run
// R11: in enable mode switch and stop control
// R12: reset restores normal run control
// R13: leave enable mode: switch Off plus reset
// R14: enable limit 1 s to 30 min, always active
// R15: enable limit expiry turns outputs Off
// R16: new cycle only after switch Off then On
// R17: output on and off delays still apply
// R18: unlatch permit node enables latch reset
// R19: latch reset only with sources Run, permit high when the permit option is set
// R20: stop drives latch output Off and holds it
// R21: reference signal mirrors its output state
// R22: reset input monitored or non-monitored selectable
// R23: monitored reset high 0.5 to 2 s, trailing
// R24: non-monitored reset high 0.5 s, leading
// R25: reset ignored unless controlling inputs Run
// R26: timers in scan ticks, cleared at reset
package sfb_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SCAN_PERIOD_NS = 1000000;
  localparam int unsigned SCAN_CYCLES    = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SCAN_PER_SEC   = 1000;
  localparam logic [15:0] BYPASS_MIN_S   = 16'h0001;
  localparam logic [15:0] BYPASS_MAX_S   = 16'hA8C0;
  localparam logic [15:0] ENABLE_MIN_S   = 16'h0001;
  localparam logic [15:0] ENABLE_MAX_S   = 16'h0708;
  localparam logic [11:0] RST_MIN_MS     = 12'h1F4;
  localparam logic [11:0] RST_MAX_MS     = 12'h7D0;
  localparam logic [11:0] RST_SAT_MS     = 12'h7D1;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_BP_LIMIT   = 8'h04;
  localparam logic [7:0]  OFS_ED_LIMIT   = 8'h08;
  localparam logic [7:0]  OFS_ON_DELAY   = 8'h0C;
  localparam logic [7:0]  OFS_OFF_DELAY  = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  localparam int unsigned CTRL_FORCE_OFF = 0;
  localparam int unsigned CTRL_MONITORED = 1;
  localparam int unsigned CTRL_PERMIT    = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam logic [15:0] BP_LIMIT_RESET = 16'h003C;
  localparam logic [15:0] ED_LIMIT_RESET = 16'h003C;
  localparam logic [15:0] DELAY_RESET    = 16'h0000;
  localparam int unsigned IN_SRC   = 0;
  localparam int unsigned IN_OVR   = 1;
  localparam int unsigned IN_TWOH  = 2;
  localparam int unsigned IN_SW    = 3;
  localparam int unsigned IN_NORM  = 4;
  localparam int unsigned IN_STOP  = 5;
  localparam int unsigned IN_LSRC  = 6;
  localparam int unsigned IN_PERM  = 7;
  localparam int unsigned IN_RST   = 8;
  localparam int unsigned IN_W     = 9;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ED_NORMAL, ED_ENABLE, ED_EXPIRED} sfb_ed_state_t;

  function automatic logic [15:0] sfb_clamp(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
    sfb_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : sfb_clamp

  function automatic logic [31:0] sfb_strb(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    sfb_strb = r;
  endfunction : sfb_strb
endpackage : sfb_pkg

// [sfb_timer.sv]
// seconds timer counting whole seconds of scan ticks up to a limit
`timescale 1ns/1ps
module sfb_timer (
  input  wire logic  sys_clk,
  input  wire logic  reset,
  input  wire logic  sec_tick,
  sfb_tmr_if.tmr     t
);
  logic [15:0] cnt_q;
  logic        exp_q;

  assign t.expired = exp_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000; // R26
      exp_q <= 1'b0;
    end else if (t.clr) begin
      cnt_q <= 16'h0000;
      exp_q <= 1'b0;
    end else if (t.run && sec_tick && !exp_q) begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q + 16'h0001 >= t.limit) exp_q <= 1'b1;
    end
  end
endmodule : sfb_timer

// [sfb_tmr_if.sv]
// interface between the block logic and a seconds timer
`timescale 1ns/1ps
interface sfb_tmr_if;
  logic        clr;
  logic        run;
  logic [15:0] limit;
  logic        expired;
  modport ctl (output clr, output run, output limit, input expired);
  modport tmr (input clr, input run, input limit, output expired);
endinterface : sfb_tmr_if

// [sfb_top.sv]
// bypass, enabling device and latch reset blocks with AXI4-Lite registers
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sfb_top #(
  parameter int unsigned SCAN_CYCLES = sfb_pkg::SCAN_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        safety_source,
  input  wire logic        override_request,
  input  wire logic        two_hand_actuated,
  input  wire logic        enable_switch,
  input  wire logic        normal_inputs,
  input  wire logic        unbypassable_stop,
  input  wire logic        latch_sources,
  input  wire logic        unlatch_permit,
  input  wire logic        operator_reset,
  output logic             bypass_out,
  output logic             two_hand_stop,
  output logic             enable_out,
  output logic             latch_out,
  output logic             referenced_output,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [sfb_pkg::IN_W-1:0] in_meta_q;
  logic [sfb_pkg::IN_W-1:0] in_q;
  logic [sfb_pkg::IN_W-1:0] prev_q;
  logic [13:0]              scan_cnt_q;
  logic                     scan_tick_q;
  logic [9:0]               sec_cnt_q;
  logic                     sec_tick_q;
  logic [2:0]               ctrl_q;
  logic [15:0]              bp_limit_q;
  logic [15:0]              ed_limit_q;
  logic [15:0]              on_delay_q;
  logic [15:0]              off_delay_q;
  logic                     bypass_d;
  logic                     ed_target_d;
  logic                     ed_target_q;
  logic [15:0]              dly_q;
  logic [11:0]              rst_len_q;
  logic                     rst_done_q;
  logic                     reset_evt_q;
  logic                     sw_rise;
  sfb_pkg::sfb_ed_state_t   ed_state_q;
  logic                     aw_have_q;
  logic                     w_have_q;
  logic [7:0]               aw_addr_q;
  logic [31:0]              w_data_q;
  logic [3:0]               w_strb_q;
  logic [31:0]              wr_old;
  logic [31:0]              wr_new;

  sfb_tmr_if bp_tmr ();
  sfb_tmr_if ed_tmr ();

  sfb_timer u_bp_timer (.sys_clk(sys_clk), .reset(reset), .sec_tick(sec_tick_q), .t(bp_tmr));
  sfb_timer u_ed_timer (.sys_clk(sys_clk), .reset(reset), .sec_tick(sec_tick_q), .t(ed_tmr));

  ////////////////////////////////////////////////////////////////////////////////
  // input synchroniser and edge history
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      in_meta_q <= '0;
      in_q      <= '0;
      prev_q    <= '0;
    end else begin
      in_meta_q <= {operator_reset, unlatch_permit, latch_sources, unbypassable_stop,
                    normal_inputs, enable_switch, two_hand_actuated, override_request,
                    safety_source};
      in_q      <= in_meta_q;
      prev_q    <= in_q;
    end
  end

  assign sw_rise = in_q[sfb_pkg::IN_SW] && !prev_q[sfb_pkg::IN_SW];

  // scan tick and seconds tick dividers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scan_cnt_q  <= 14'h0000; // R26
      scan_tick_q <= 1'b0;
      sec_cnt_q   <= 10'h000;
      sec_tick_q  <= 1'b0;
    end else begin
      scan_tick_q <= 1'b0;
      sec_tick_q  <= 1'b0;
      if (scan_cnt_q == 14'(SCAN_CYCLES - 1)) begin
        scan_cnt_q  <= 14'h0000;
        scan_tick_q <= 1'b1;
      end else begin
        scan_cnt_q <= scan_cnt_q + 14'h0001;
      end
      if (scan_tick_q) begin
        if (sec_cnt_q == 10'(sfb_pkg::SCAN_PER_SEC - 1)) begin
          sec_cnt_q  <= 10'h000;
          sec_tick_q <= 1'b1;
        end else begin
          sec_cnt_q <= sec_cnt_q + 10'h001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bypass block
  assign bp_tmr.clr   = !in_q[sfb_pkg::IN_OVR]; // R6
  assign bp_tmr.run   = in_q[sfb_pkg::IN_OVR];
  assign bp_tmr.limit = bp_limit_q; // R5

  always_comb begin
    if (!in_q[sfb_pkg::IN_OVR]) begin
      bypass_d = in_q[sfb_pkg::IN_SRC]; // R1
    end else if (bp_tmr.expired) begin
      bypass_d = 1'b0; // R3
    end else if (ctrl_q[sfb_pkg::CTRL_FORCE_OFF] && in_q[sfb_pkg::IN_SRC]) begin
      bypass_d = 1'b0; // R2
    end else begin
      bypass_d = 1'b1; // R2
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bypass_out    <= 1'b0;
      two_hand_stop <= 1'b0;
    end else begin
      bypass_out    <= bypass_d;
      two_hand_stop <= in_q[sfb_pkg::IN_OVR] && in_q[sfb_pkg::IN_TWOH]; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operator reset qualification
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_len_q   <= 12'h000;
      rst_done_q  <= 1'b0;
      reset_evt_q <= 1'b0;
    end else begin
      reset_evt_q <= 1'b0;
      if (!in_q[sfb_pkg::IN_RST]) begin
        rst_len_q  <= 12'h000;
        rst_done_q <= 1'b0;
        if (prev_q[sfb_pkg::IN_RST] && ctrl_q[sfb_pkg::CTRL_MONITORED] &&
            rst_len_q >= sfb_pkg::RST_MIN_MS && rst_len_q <= sfb_pkg::RST_MAX_MS) begin
          reset_evt_q <= 1'b1; // R22 R23
        end
      end else begin
        if (scan_tick_q && rst_len_q != sfb_pkg::RST_SAT_MS) rst_len_q <= rst_len_q + 12'h001;
        if (!ctrl_q[sfb_pkg::CTRL_MONITORED] && !rst_done_q &&
            rst_len_q >= sfb_pkg::RST_MIN_MS) begin
          reset_evt_q <= 1'b1; // R22 R24
          rst_done_q  <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // enabling device block
  assign ed_tmr.clr   = (ed_state_q != sfb_pkg::ED_ENABLE); // R16
  assign ed_tmr.run   = (ed_state_q == sfb_pkg::ED_ENABLE);
  assign ed_tmr.limit = ed_limit_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ed_state_q <= sfb_pkg::ED_NORMAL;
    end else begin
      case (ed_state_q)
        sfb_pkg::ED_NORMAL: begin
          if (sw_rise) ed_state_q <= sfb_pkg::ED_ENABLE; // R10
        end
        sfb_pkg::ED_ENABLE: begin
          if (reset_evt_q && !in_q[sfb_pkg::IN_SW]) begin
            ed_state_q <= sfb_pkg::ED_NORMAL; // R12 R13
          end else if (ed_tmr.expired) begin
            ed_state_q <= sfb_pkg::ED_EXPIRED; // R15
          end
        end
        sfb_pkg::ED_EXPIRED: begin
          if (reset_evt_q && !in_q[sfb_pkg::IN_SW]) begin
            ed_state_q <= sfb_pkg::ED_NORMAL; // R13
          end else if (sw_rise) begin
            ed_state_q <= sfb_pkg::ED_ENABLE; // R16
          end
        end
        default: ed_state_q <= sfb_pkg::ED_NORMAL;
      endcase
    end
  end

  always_comb begin
    case (ed_state_q)
      sfb_pkg::ED_NORMAL: ed_target_d = in_q[sfb_pkg::IN_NORM] && in_q[sfb_pkg::IN_STOP];
      sfb_pkg::ED_ENABLE: ed_target_d = in_q[sfb_pkg::IN_SW] && in_q[sfb_pkg::IN_STOP]; // R9 R11
      default:            ed_target_d = 1'b0; // R15
    endcase
  end

  // output delay stage; the final output feeds the output block directly
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ed_target_q       <= 1'b0;
      dly_q             <= 16'h0000;
      enable_out        <= 1'b0;
      referenced_output <= 1'b0;
    end else begin
      ed_target_q <= ed_target_d;
      if (ed_target_q == enable_out) begin
        dly_q <= 16'h0000;
      end else if (dly_q >= (ed_target_q ? on_delay_q : off_delay_q)) begin
        enable_out        <= ed_target_q; // R17 R8
        referenced_output <= ed_target_q; // R21
        dly_q             <= 16'h0000;
      end else if (scan_tick_q) begin
        dly_q <= dly_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // latch reset block, stop dominant
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      latch_out <= 1'b0; // R26
    end else if (!in_q[sfb_pkg::IN_LSRC]) begin
      latch_out <= 1'b0; // R20 R25
    end else if (reset_evt_q &&
                 (!ctrl_q[sfb_pkg::CTRL_PERMIT] || in_q[sfb_pkg::IN_PERM])) begin
      latch_out <= 1'b1; // R18 R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  // byte-lane merge of the pending write into the addressed register
  always_comb begin
    case (aw_addr_q)
      sfb_pkg::OFS_CTRL:      wr_old = {29'h0, ctrl_q};
      sfb_pkg::OFS_BP_LIMIT:  wr_old = {16'h0, bp_limit_q};
      sfb_pkg::OFS_ED_LIMIT:  wr_old = {16'h0, ed_limit_q};
      sfb_pkg::OFS_ON_DELAY:  wr_old = {16'h0, on_delay_q};
      sfb_pkg::OFS_OFF_DELAY: wr_old = {16'h0, off_delay_q};
      default:                wr_old = 32'h0000_0000;
    endcase
    wr_new = sfb_pkg::sfb_strb(wr_old, w_data_q, w_strb_q);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sfb_pkg::RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      ctrl_q        <= sfb_pkg::CTRL_RESET;
      bp_limit_q    <= sfb_pkg::BP_LIMIT_RESET;
      ed_limit_q    <= sfb_pkg::ED_LIMIT_RESET;
      on_delay_q    <= sfb_pkg::DELAY_RESET;
      off_delay_q   <= sfb_pkg::DELAY_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= sfb_pkg::RESP_OKAY;
        case (aw_addr_q)
          sfb_pkg::OFS_CTRL:      ctrl_q      <= wr_new[2:0];
          sfb_pkg::OFS_BP_LIMIT:
            bp_limit_q <= sfb_pkg::sfb_clamp(wr_new[15:0], sfb_pkg::BYPASS_MIN_S,
                                             sfb_pkg::BYPASS_MAX_S); // R4
          sfb_pkg::OFS_ED_LIMIT:
            ed_limit_q <= sfb_pkg::sfb_clamp(wr_new[15:0], sfb_pkg::ENABLE_MIN_S,
                                             sfb_pkg::ENABLE_MAX_S); // R14
          sfb_pkg::OFS_ON_DELAY:  on_delay_q  <= wr_new[15:0];
          sfb_pkg::OFS_OFF_DELAY: off_delay_q <= wr_new[15:0];
          sfb_pkg::OFS_STATUS: s_axi_bresp <= sfb_pkg::RESP_OKAY;
          default: s_axi_bresp <= sfb_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sfb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= sfb_pkg::RESP_OKAY;
      case (s_axi_araddr)
        sfb_pkg::OFS_CTRL:      s_axi_rdata <= {29'h0, ctrl_q};
        sfb_pkg::OFS_BP_LIMIT:  s_axi_rdata <= {16'h0, bp_limit_q};
        sfb_pkg::OFS_ED_LIMIT:  s_axi_rdata <= {16'h0, ed_limit_q};
        sfb_pkg::OFS_ON_DELAY:  s_axi_rdata <= {16'h0, on_delay_q};
        sfb_pkg::OFS_OFF_DELAY: s_axi_rdata <= {16'h0, off_delay_q};
        sfb_pkg::OFS_STATUS:
          s_axi_rdata <= {24'h0, (ed_state_q == sfb_pkg::ED_EXPIRED),
                          (ed_state_q == sfb_pkg::ED_ENABLE), ed_tmr.expired,
                          bp_tmr.expired, latch_out, enable_out, two_hand_stop, bypass_out};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= sfb_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_bp_follow;
    @(posedge sys_clk) disable iff (reset)
    !$past(in_q[sfb_pkg::IN_OVR]) |-> (bypass_out == $past(in_q[sfb_pkg::IN_SRC]));
  endproperty
  a_bp_follow: assert property (p_bp_follow) else $error("bypass output not following source"); // R1

  property p_bp_on;
    @(posedge sys_clk) disable iff (reset)
    $past(in_q[sfb_pkg::IN_OVR] && !bp_tmr.expired && !in_q[sfb_pkg::IN_SRC]) |-> bypass_out;
  endproperty
  a_bp_on: assert property (p_bp_on) else $error("override did not hold output on"); // R2

  property p_bp_expire;
    @(posedge sys_clk) disable iff (reset)
    $past(in_q[sfb_pkg::IN_OVR] && bp_tmr.expired) |-> !bypass_out;
  endproperty
  a_bp_expire: assert property (p_bp_expire) else $error("expired bypass left output on"); // R3

  property p_bp_limit;
    @(posedge sys_clk) disable iff (reset)
    (bp_limit_q >= sfb_pkg::BYPASS_MIN_S) && (bp_limit_q <= sfb_pkg::BYPASS_MAX_S);
  endproperty
  a_bp_limit: assert property (p_bp_limit) else $error("bypass limit out of range"); // R4

  property p_two_hand;
    @(posedge sys_clk) disable iff (reset)
    (in_q[sfb_pkg::IN_OVR] && in_q[sfb_pkg::IN_TWOH]) |=> two_hand_stop;
  endproperty
  a_two_hand: assert property (p_two_hand) else $error("two-hand stop not issued"); // R7

  property p_ed_stop;
    @(posedge sys_clk) disable iff (reset)
    !in_q[sfb_pkg::IN_STOP] |=> !ed_target_q;
  endproperty
  a_ed_stop: assert property (p_ed_stop) else $error("stop overridden in enable path"); // R9

  property p_ed_enter;
    @(posedge sys_clk) disable iff (reset)
    (ed_state_q == sfb_pkg::ED_NORMAL) && sw_rise |=> (ed_state_q == sfb_pkg::ED_ENABLE);
  endproperty
  a_ed_enter: assert property (p_ed_enter) else $error("enable mode not entered"); // R10

  property p_ed_exit;
    @(posedge sys_clk) disable iff (reset)
    ($past(ed_state_q) == sfb_pkg::ED_ENABLE) && (ed_state_q == sfb_pkg::ED_NORMAL)
      |-> $past(reset_evt_q) && !$past(in_q[sfb_pkg::IN_SW]);
  endproperty
  a_ed_exit: assert property (p_ed_exit) else $error("enable mode left without reset"); // R13

  property p_ed_expired;
    @(posedge sys_clk) disable iff (reset)
    (ed_state_q == sfb_pkg::ED_EXPIRED) && !sw_rise |=> (ed_state_q != sfb_pkg::ED_ENABLE)
      ##0 !ed_target_q;
  endproperty
  a_ed_expired: assert property (p_ed_expired) else $error("expired enable restarted"); // R15 R16

  property p_latch_stop;
    @(posedge sys_clk) disable iff (reset)
    !in_q[sfb_pkg::IN_LSRC] |=> !latch_out ##1 (!latch_out || $past(reset_evt_q));
  endproperty
  a_latch_stop: assert property (p_latch_stop) else $error("latch not held off at stop"); // R20
endmodule : sfb_top

// [sfb_top_tb.sv]
// self-checking bench for the safety function blocks
`timescale 1ns/1ps
module sfb_top_tb;
  localparam logic [1:0] OK = sfb_pkg::RESP_OKAY;
  localparam logic [1:0] SE = sfb_pkg::RESP_SLVERR;
  logic sys_clk = 1'h0, reset = 1'h1, safety_source = 1'h0, override_request = 1'h0;
  logic two_hand_actuated = 1'h0, enable_switch = 1'h0, normal_inputs = 1'h0;
  logic unbypassable_stop = 1'h0, latch_sources = 1'h0, unlatch_permit = 1'h0;
  logic operator_reset, bypass_out, two_hand_stop, enable_out, latch_out, referenced_output;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0, n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  sfb_top #(.SCAN_CYCLES(4)) sfb_top_i (
    .sys_clk, .reset, .safety_source, .override_request, .two_hand_actuated, .enable_switch,
    .normal_inputs, .unbypassable_stop, .latch_sources, .unlatch_permit, .operator_reset,
    .bypass_out, .two_hand_stop, .enable_out, .latch_out, .referenced_output,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sfb_button sfb_button_i (.sys_clk, .operator_reset);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er, "bresp");
    cyc(1);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed, "rdata");
    chk(s_axi_rresp, er, "rresp");
    cyc(1);
  endtask : axr
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axr(sfb_pkg::OFS_CTRL, 32'h0, OK);
    axr(sfb_pkg::OFS_BP_LIMIT, 32'h3C, OK);
    axr(sfb_pkg::OFS_ED_LIMIT, 32'h3C, OK);
    axw(8'h40, 32'hFFFF, SE);
    axr(8'h40, 32'h0, SE);
    axw(sfb_pkg::OFS_BP_LIMIT, 32'hFFFF, OK);
    axr(sfb_pkg::OFS_BP_LIMIT, 32'hA8C0, OK);
    axw(sfb_pkg::OFS_BP_LIMIT, 32'h0, OK);
    axr(sfb_pkg::OFS_BP_LIMIT, 32'h1, OK);
    axw(sfb_pkg::OFS_ED_LIMIT, 32'hFFFF, OK);
    axr(sfb_pkg::OFS_ED_LIMIT, 32'h708, OK);
    s_axi_wstrb <= 4'h1;
    axw(sfb_pkg::OFS_OFF_DELAY, 32'hFF03, OK);
    axr(sfb_pkg::OFS_OFF_DELAY, 32'h3, OK);
    s_axi_wstrb <= 4'hF;
    axw(sfb_pkg::OFS_OFF_DELAY, 32'h0, OK);
    axw(sfb_pkg::OFS_BP_LIMIT, 32'h2, OK);
    axw(sfb_pkg::OFS_ED_LIMIT, 32'h2, OK);
  endtask : t_regs
  task automatic t_byp();
    int n;
    safety_source <= 1'h1;
    cyc(8);
    chk(bypass_out, 1'h1, "follow on");
    safety_source <= 1'h0;
    override_request <= 1'h1;
    two_hand_actuated <= 1'h1;
    cyc(8);
    chk(bypass_out, 1'h1, "override");
    chk(two_hand_stop, 1'h1, "two hand");
    two_hand_actuated <= 1'h0;
    for (n = 0; n < 9000 && bypass_out !== 1'h0; n++) @(posedge sys_clk);
    chk(bypass_out, 1'h0, "expiry");
    chk(two_hand_stop, 1'h0, "two hand off");
    safety_source <= 1'h1;
    cyc(8);
    chk(bypass_out, 1'h0, "held off");
    axr(sfb_pkg::OFS_STATUS, 32'h10, OK);
    override_request <= 1'h0;
    cyc(8);
    chk(bypass_out, 1'h1, "handback");
    axw(sfb_pkg::OFS_CTRL, 32'h1, OK);
    override_request <= 1'h1;
    cyc(8);
    chk(bypass_out, 1'h0, "force off");
    safety_source <= 1'h0;
    cyc(8);
    chk(bypass_out, 1'h1, "override src off");
    override_request <= 1'h0;
  endtask : t_byp
  task automatic t_en();
    int n;
    axw(sfb_pkg::OFS_CTRL, 32'h0, OK);
    normal_inputs <= 1'h1;
    unbypassable_stop <= 1'h1;
    cyc(8);
    chk(enable_out, 1'h1, "normal");
    enable_switch <= 1'h1;
    normal_inputs <= 1'h0;
    cyc(8);
    chk(enable_out, 1'h1, "enable");
    unbypassable_stop <= 1'h0;
    cyc(8);
    chk(enable_out, 1'h0, "stop");
    chk(referenced_output, 1'h0, "ref off");
    unbypassable_stop <= 1'h1;
    cyc(8);
    chk(referenced_output, 1'h1, "ref on");
    for (n = 0; n < 9000 && enable_out !== 1'h0; n++) @(posedge sys_clk);
    chk(enable_out, 1'h0, "expiry");
    enable_switch <= 1'h0;
    axw(sfb_pkg::OFS_ON_DELAY, 32'hA, OK);
    enable_switch <= 1'h1;
    cyc(8);
    chk(enable_out, 1'h0, "on delay");
    cyc(48);
    chk(enable_out, 1'h1, "new cycle");
    enable_switch <= 1'h0;
    normal_inputs <= 1'h1;
    cyc(8);
    chk(enable_out, 1'h0, "no exit");
    fork sfb_button_i.hold(2200); join_none
    cyc(2300);
    chk(enable_out, 1'h1, "exit");
    chk(latch_out, 1'h0, "src not run");
    axw(sfb_pkg::OFS_ON_DELAY, 32'h0, OK);
  endtask : t_en
  task automatic t_latch();
    latch_sources <= 1'h1;
    fork sfb_button_i.hold(2200); join_none
    cyc(1500);
    chk(latch_out, 1'h0, "early");
    cyc(800);
    chk(latch_out, 1'h1, "leading");
    latch_sources <= 1'h0;
    cyc(8);
    latch_sources <= 1'h1;
    cyc(8);
    chk(latch_out, 1'h0, "stop latch");
    axw(sfb_pkg::OFS_CTRL, 32'h4, OK);
    fork sfb_button_i.hold(2200); join_none
    cyc(2300);
    chk(latch_out, 1'h0, "no permit");
    unlatch_permit <= 1'h1;
    axw(sfb_pkg::OFS_CTRL, 32'h6, OK);
    fork sfb_button_i.hold(2200); join_none
    cyc(2150);
    chk(latch_out, 1'h0, "trailing");
    cyc(150);
    chk(latch_out, 1'h1, "monitored");
    latch_sources <= 1'h0;
    cyc(8);
    latch_sources <= 1'h1;
    fork sfb_button_i.hold(1000); join_none
    cyc(1100);
    chk(latch_out, 1'h0, "short press");
  endtask : t_latch
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    $display("[ERR] %0t watchdog", $time);
    finish_test();
  end
  initial begin
    cyc(5);
    chk(latch_out, 1'h0, "reset");
    reset <= 1'h0;
    cyc(2);
    t_regs();
    t_byp();
    t_en();
    t_latch();
    finish_test();
  end
endmodule : sfb_top_tb
